// >>> src/inhibit_consts.svh
// Constants for the output inhibit controller
`ifndef INHIBIT_CONSTS_SVH
`define INHIBIT_CONSTS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h4
`define ADDR_VMEAS 4'h8
`define ADDR_IMEAS 4'hc
`define CTRL_OUT_EN 0
`define CTRL_LATCH_MODE 1
`define CTRL_POL_NEG 2
`define CTRL_CLEAR 3
`define STAT_INHIBITED 0
`define STAT_LATCHED 1
`define STAT_INPUT 2
`define STAT_OUTPUT 3
`define CTRL_RESET 3'h0
`define METER_W 16
`endif

// >>> src/inhibit_pkg.sv
// Types for the output inhibit controller
package inhibit_pkg;
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
  } meter_t;
  typedef enum logic {MODE_LIVE, MODE_LATCH} inh_mode_t;
endpackage

// >>> src/inhibit_core.sv
// Inhibit decision core: polarity, latch and gating
`timescale 1ns/1ps
`include "inhibit_consts.svh"
module inhibit_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inh_pin,
  input wire logic pol_neg,
  input wire inhibit_pkg::inh_mode_t mode,
  input wire logic clear,
  output logic inh_true,
  output logic latched,
  output logic blocked
);
  import inhibit_pkg::*;
  logic latch_q;
  logic latch_d;
  always_comb begin
    inh_true = inh_pin ^ pol_neg;
    latch_d = latch_q;
    // Leaving latching mode must not free a tripped latch; only a valid clear does
    if (mode == MODE_LATCH && inh_true) begin
      latch_d = 1'b1;
    end else if (clear && !inh_true) begin
      latch_d = 1'b0;
    end
    latched = latch_q;
    blocked = inh_true | latch_q;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end
  a_latch_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    (latch_q && !(clear && !inh_true)) |=> latch_q)
    else $error("latch released without a valid clear");
  a_clear_blocked: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mode == MODE_LATCH && inh_true) |=> latch_q)
    else $error("latch not set while inhibit true");
  a_live_nolatch: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mode == MODE_LIVE && !latch_q) |=> !latch_q)
    else $error("latch set in live mode");
endmodule

// >>> src/output_inhibit_control.sv
// Wishbone top of the output inhibit controller
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "inhibit_consts.svh"
module output_inhibit_control (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic INHIBIT_PIN,
  input wire logic [15:0] VOLT_RAW,
  input wire logic [15:0] CURR_RAW,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic OUTPUT_ON,
  output logic INHIBITED_INDICATOR,
  output inhibit_pkg::meter_t METER
);
  import inhibit_pkg::*;

  // Configuration written by software
  logic out_en_q;
  logic out_en_d;
  logic mode_q;
  logic mode_d;
  logic pol_q;
  logic pol_d;
  logic clear_q;
  logic clear_d;

  // Bus answer
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  // Registered results seen outside
  logic on_q;
  logic on_d;
  logic ind_q;
  logic ind_d;
  meter_t meter_q;
  meter_t meter_d;

  // Core results and bus decode
  logic inh_true;
  logic latched;
  logic blocked;
  logic inh_show;
  logic req;
  logic wr;
  logic rd;
  logic sel_ctrl;
  logic [1:0][`METER_W-1:0] raw_ch;
  logic [1:0][`METER_W-1:0] gated_ch;
  inh_mode_t mode_e;

  assign mode_e = mode_q ? MODE_LATCH : MODE_LIVE;

  inhibit_core u_core (
    .clk(CLK),
    .rst_b(RST_B),
    .inh_pin(INHIBIT_PIN),
    .pol_neg(pol_q),
    .mode(mode_e),
    .clear(clear_q),
    .inh_true(inh_true),
    .latched(latched),
    .blocked(blocked)
  );

  // Single cycle ack; the ack_q term keeps one request from being acked twice
  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  // A write without the low byte lane is acked but changes nothing
  assign wr = req & WB_WE_I & WB_SEL_I[0];
  assign rd = req & ~WB_WE_I;
  assign sel_ctrl = (WB_ADR_I == `ADDR_CTRL);

  always_comb begin
    out_en_d = out_en_q;
    mode_d = mode_q;
    pol_d = pol_q;
    clear_d = 1'b0;
    if (wr && sel_ctrl) begin
      out_en_d = WB_DAT_I[`CTRL_OUT_EN];
      mode_d = WB_DAT_I[`CTRL_LATCH_MODE];
      pol_d = WB_DAT_I[`CTRL_POL_NEG];
      clear_d = WB_DAT_I[`CTRL_CLEAR];
    end
    // Clear forces the enable setting off, even if the same write set it
    if (clear_q) begin
      out_en_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {pol_q, mode_q, out_en_q} <= `CTRL_RESET;
      clear_q <= 1'b0;
    end else begin
      out_en_q <= out_en_d;
      mode_q <= mode_d;
      pol_q <= pol_d;
      clear_q <= clear_d;
    end
  end

  always_comb begin
    ack_d = req;
    dat_d = 32'h0;
    if (rd) begin
      unique case (WB_ADR_I)
        `ADDR_CTRL: begin
          dat_d[`CTRL_OUT_EN] = out_en_q;
          dat_d[`CTRL_LATCH_MODE] = mode_q;
          dat_d[`CTRL_POL_NEG] = pol_q;
        end
        `ADDR_STAT: begin
          dat_d[`STAT_INHIBITED] = ind_q;
          dat_d[`STAT_LATCHED] = latched;
          dat_d[`STAT_INPUT] = inh_true;
          dat_d[`STAT_OUTPUT] = on_q;
        end
        `ADDR_VMEAS: dat_d[`METER_W-1:0] = meter_q.volt;
        `ADDR_IMEAS: dat_d[`METER_W-1:0] = meter_q.curr;
        default: dat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Indicator only while the enable setting would otherwise have the output on
  assign inh_show = blocked & out_en_q;
  assign raw_ch = {VOLT_RAW, CURR_RAW};
  for (genvar g = 0; g < 2; g++) begin : g_meter
    assign gated_ch[g] = inh_show ? {`METER_W{1'b0}} : raw_ch[g];
  end

  always_comb begin
    on_d = out_en_q & ~blocked;
    ind_d = inh_show;
    meter_d.volt = gated_ch[1];
    meter_d.curr = gated_ch[0];
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      on_q <= 1'b0;
      ind_q <= 1'b0;
      meter_q <= '0;
    end else begin
      on_q <= on_d;
      ind_q <= ind_d;
      meter_q <= meter_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign OUTPUT_ON = on_q;
  assign INHIBITED_INDICATOR = ind_q;
  assign METER = meter_q;

  a_live_follow: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!mode_q && inh_true) |=> !OUTPUT_ON)
    else $error("output on while live inhibit true");

  a_live_return: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!mode_q && !inh_true && !latched && out_en_q) |=> OUTPUT_ON)
    else $error("output not restored in live mode");

  a_latch_off: assert property (
    @(posedge CLK) disable iff (!RST_B)
    latched |=> !OUTPUT_ON)
    else $error("output on while latched");

  a_clear_disables: assert property (
    @(posedge CLK) disable iff (!RST_B)
    clear_q |=> !out_en_q)
    else $error("enable kept after clear");

  a_meter_zero: assert property (
    @(posedge CLK) disable iff (!RST_B)
    INHIBITED_INDICATOR |-> (METER.volt == 16'h0 && METER.curr == 16'h0))
    else $error("meter not zero while inhibited");

  a_pol_level: assert property (
    @(posedge CLK) disable iff (!RST_B)
    inh_true == (INHIBIT_PIN ^ pol_q))
    else $error("polarity correction wrong");

  a_release_rule: assert property (
    @(posedge CLK) disable iff (!RST_B)
    $fell(latched) |-> ($past(clear_q) && !$past(inh_true)))
    else $error("latch released without a valid clear");

  a_ack_once: assert property (
    @(posedge CLK) disable iff (!RST_B)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

  a_ack_answer: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("request not acked");

  a_ack_idle: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");

  a_rdata_idle: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !WB_ACK_O |-> (WB_DAT_O == 32'h0))
    else $error("read data outside ack");

  a_unmapped_zero: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (rd && WB_ADR_I[1:0] != 2'b00) |=> (WB_DAT_O == 32'h0))
    else $error("unmapped read not zero");

  a_sel_ignored: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (req && WB_WE_I && !WB_SEL_I[0] && !clear_q) |=> $stable(out_en_q))
    else $error("write without low lane changed enable");

  a_pol_set: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr && sel_ctrl && WB_DAT_I[`CTRL_POL_NEG]) |=> pol_q)
    else $error("negative polarity not taken");

  a_pol_clear: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (wr && sel_ctrl && !WB_DAT_I[`CTRL_POL_NEG]) |=> !pol_q)
    else $error("positive polarity not taken");

  a_clear_pulse: assert property (
    @(posedge CLK) disable iff (!RST_B)
    clear_q |=> !clear_q)
    else $error("clear pulse held");

  a_clear_refused: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (clear_q && inh_true && latched) |=> latched)
    else $error("clear freed latch while inhibit true");

  a_live_no_set: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (!mode_q && !latched) |=> !latched)
    else $error("live mode tripped the latch");

  a_latch_trip: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (mode_q && inh_true) |=> (latched && !OUTPUT_ON))
    else $error("latching mode did not trip");

  a_level_block: assert property (
    @(posedge CLK) disable iff (!RST_B)
    inh_true |=> !OUTPUT_ON)
    else $error("output on while input asserted");

  a_enable_gate: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !out_en_q |=> !OUTPUT_ON)
    else $error("output on without enable");

  a_ind_excl: assert property (
    @(posedge CLK) disable iff (!RST_B)
    INHIBITED_INDICATOR |-> !OUTPUT_ON)
    else $error("indicator with output on");

  a_ind_show: assert property (
    @(posedge CLK) disable iff (!RST_B)
    inh_show |=> INHIBITED_INDICATOR)
    else $error("indicator missing while inhibited");

  a_ind_quiet: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !inh_show |=> !INHIBITED_INDICATOR)
    else $error("indicator without inhibit");

  a_meter_pass: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !inh_show |=> (METER.volt == $past(VOLT_RAW) && METER.curr == $past(CURR_RAW)))
    else $error("meter not passed through");

  a_stat_latch: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (rd && WB_ADR_I == `ADDR_STAT) |=> (WB_DAT_O[`STAT_LATCHED] == $past(latched)))
    else $error("status latch bit wrong");
endmodule

// >>> tb/inhibit_switch.sv
// External inhibit switch with the input's pull-up
`timescale 1ns/1ps
module inhibit_switch (
  input wire logic closed,
  output logic pin
);
  // An open switch leaves the pull-up in charge, so never a stale level
  assign pin = ~closed;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the output inhibit controller
`timescale 1ns/1ps
module testbench;
  import inhibit_pkg::*;
  logic clk = 0, rst_b = 0, closed = 0, pin, cyc = 0, stb = 0, we = 0;
  logic ack, on, ind, pol, b;
  logic [3:0] adr = 0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wd = 0, rd, r;
  logic [15:0] v = 0, c = 0;
  meter_t m;
  int failures = 0, comparisons = 0;
  always #25 clk = ~clk;
  inhibit_switch sw_u (.closed(closed), .pin(pin));
  output_inhibit_control dut_u (.CLK(clk), .RST_B(rst_b), .INHIBIT_PIN(pin),
    .VOLT_RAW(v), .CURR_RAW(c), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .OUTPUT_ON(on), .INHIBITED_INDICATOR(ind), .METER(m));
  function automatic logic exp_on(input logic en, input logic lat, input logic inhibited_indicator);
    return en & ~lat & ~inhibited_indicator;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test;
    end
    r = rd;
    cyc <= 0;
    stb <= 0;
  endtask
  // Drive the corrected inhibit level, then let it settle
  task automatic drv(input logic inhibited_indicator);
    @(posedge clk);
    closed <= ~(inhibited_indicator ^ pol);
    repeat (4) @(posedge clk);
  endtask
  task automatic look(input logic e_on, input logic e_ind);
    chk({31'h0, on}, {31'h0, e_on});
    chk({31'h0, ind}, {31'h0, e_ind});
    chk(m, e_ind ? 32'h0 : {v, c});
  endtask
  initial begin
    void'($urandom(25));
    pol = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    v <= 16'($urandom);
    c <= 16'($urandom);
    wb(0, 4'h2, 0);
    chk(r, 0);
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      wb(1, 4'h0, {29'h0, pol, 2'b01});
      drv(1);
      look(0, 1);
      wb(0, 4'h4, 0);
      chk(r, 32'h5);
      drv(0);
      look(1, 0);
    end
    wb(1, 4'h0, 32'h4);
    drv(0);
    look(0, 0);
    wb(1, 4'h0, 32'h5);
    for (int i = 0; i < 8; i++) begin
      b = 1'($urandom);
      drv(b);
      look(exp_on(1, 0, b), b);
    end
    wb(1, 4'h0, 32'h7);
    drv(1);
    drv(0);
    look(0, 1);
    // Leaving latching mode must not free the tripped latch
    wb(1, 4'h0, 32'h5);
    drv(0);
    look(0, 1);
    drv(1);
    wb(1, 4'h0, 32'he);
    drv(0);
    wb(0, 4'h4, 0);
    chk(r, 32'h2);
    // The input is already false before the clear goes out
    wb(1, 4'h0, 32'hf);
    repeat (3) @(posedge clk);
    wb(0, 4'h0, 0);
    chk(r, 32'h6);
    wb(0, 4'h4, 0);
    chk(r, 32'h0);
    look(0, 0);
    wb(1, 4'h0, 32'h7);
    repeat (3) @(posedge clk);
    look(1, 0);
    @(posedge clk);
    sel <= 4'h0;
    wb(1, 4'h0, 32'h0);
    sel <= 4'hf;
    wb(0, 4'h0, 0);
    chk(r, 32'h7);
    wb(0, 4'h8, 0);
    chk(r, {16'h0, v});
    wb(0, 4'hc, 0);
    chk(r, {16'h0, c});
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    chk({30'h0, on, ind}, 32'h0);
    chk(m, 32'h0);
    rst_b <= 1;
    wb(0, 4'h0, 0);
    chk(r, 32'h0);
    end_of_test;
  end
  initial begin
    #200us;
    failures++;
    end_of_test;
  end
endmodule
